/* pkg/ebac_pkg.sv */
// Constants and types for the byte-wide nonvolatile access controller
// Function
// - 1K-byte nonvolatile space, byte read and write
// - Self-timed write with completion flag
// - Read stalls the core four cycles
// - Write launch stalls the core two cycles
// - Write in progress survives reset
// - Writes need the unlock sequence
// - Low I/O range is bit-accessible
// - Port addresses plus 0x20 give data addresses
// - Extended range only via load and store
// - Bit set/clear touches only that bit
// - Three scratch registers, low one bit-accessible
// - Ten-bit address split high and low
// - Address registers undefined after reset
// - High address at data offset 0x42
// - Low address at data offset 0x41
// - Unlock clears after four cycles, gates strobe
// - Action select field, frozen while busy
// - Strobe clears on completion, ready interrupt
// - Busy blocks reads and address changes
`default_nettype none

package ebac_pkg;

   // ******************************************
   // Array geometry
   // ******************************************
   localparam int NV_BYTES = 1024;
   localparam int NV_AW    = 10;
   localparam int ADDR_HI_W = 2;

   // ******************************************
   // Register map, data-space offsets
   // ******************************************
   localparam logic [7:0] DS_SCR0    = 8'h3e;
   localparam logic [7:0] DS_CTRL    = 8'h3f;
   localparam logic [7:0] DS_DATA    = 8'h40;
   localparam logic [7:0] DS_ADDR_LO = 8'h41;
   localparam logic [7:0] DS_ADDR_HI = 8'h42;
   localparam logic [7:0] DS_SCR1    = 8'h4a;
   localparam logic [7:0] DS_SCR2    = 8'h4b;
   localparam logic [7:0] IO_TO_DS   = 8'h20;
   localparam logic [7:0] IO_LIMIT   = 8'h40;
   localparam logic [7:0] BIT_LIMIT  = 8'h20;

   // ******************************************
   // Control register fields and reset values
   // ******************************************
   localparam int CTRL_READ_BIT   = 0;
   localparam int CTRL_STROBE_BIT = 1;
   localparam int CTRL_UNLOCK_BIT = 2;
   localparam int CTRL_IRQEN_BIT  = 3;
   localparam int CTRL_MODE_LSB   = 4;
   localparam int CTRL_MODE_MSB   = 5;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] SCR_RST  = 8'h00;

   // ******************************************
   // Timing
   // ******************************************
   localparam int CLK_PERIOD_NS  = 100;
   localparam int UNLOCK_CYC     = 4;
   localparam int RD_STALL_CYC   = 4;
   localparam int WR_STALL_CYC   = 2;
   localparam int T_ATOMIC_NS    = 3400000;
   localparam int T_SPLIT_NS     = 1800000;
   localparam int ATOMIC_CYC     = T_ATOMIC_NS / CLK_PERIOD_NS;
   localparam int SPLIT_CYC      = T_SPLIT_NS / CLK_PERIOD_NS;
   localparam int PROG_W         = 16;
   localparam int STALL_W        = 3;
   localparam int UNLOCK_W       = 3;

   typedef enum logic [1:0] {
      PM_ATOMIC = 2'b00,
      PM_ERASE  = 2'b01,
      PM_WRITE  = 2'b10,
      PM_RSVD   = 2'b11
   } ebac_pm_e;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_IN   = 3'b001,
      OP_OUT  = 3'b010,
      OP_LD   = 3'b011,
      OP_ST   = 3'b100,
      OP_SBI  = 3'b101,
      OP_CBI  = 3'b110,
      OP_TST  = 3'b111
   } ebac_op_e;

   // One core access per cycle
   typedef struct packed {
      ebac_op_e   op;
      logic [7:0] addr;
      logic [2:0] bit_idx;
      logic [7:0] wdata;
   } ebac_req_s;

   localparam ebac_pm_e MODE_RST = PM_ATOMIC;

endpackage

`default_nettype wire

/* test/ebac_core_model.sv */
// Processor core model issuing register accesses and byte sequences
`timescale 1ns/1ns
`default_nettype none
module ebac_core_model (
   input  wire logic             clk_i,
   input  wire logic             stall_i,
   output var ebac_pkg::ebac_req_s req_o
);
   import ebac_pkg::*;
   // ************
   // Accesses
   // ************
   initial req_o = '0;
   // One access per call; the core waits out any stall before issuing
   task automatic acc(input ebac_op_e op, input logic [7:0] ad, input logic [2:0] bi,
                      input logic [7:0] wd);
      @(negedge clk_i);
      while (stall_i === 1'b1) @(negedge clk_i);
      req_o = '{op, ad, bi, wd};
      @(negedge clk_i);
      req_o.op = OP_NONE;
   endtask
   // Address first, then data, then the unlock store if unl is set, then the strobe
   task automatic nv_write(input logic [9:0] a, input logic [7:0] d, input logic [1:0] m,
                           input bit unl);
      acc(OP_ST, DS_ADDR_LO, 3'h0, a[7:0]);
      acc(OP_ST, DS_ADDR_HI, 3'h0, {6'h00, a[9:8]});
      acc(OP_ST, DS_DATA, 3'h0, d);
      if (unl) acc(OP_ST, DS_CTRL, 3'h0, {2'h0, m, 4'hc});
      acc(OP_ST, DS_CTRL, 3'h0, {2'h0, m, unl ? 4'he : 4'ha});
   endtask
   // Read strobe with the ready level kept enabled
   task automatic nv_read(input logic [9:0] a);
      acc(OP_ST, DS_ADDR_LO, 3'h0, a[7:0]);
      acc(OP_ST, DS_ADDR_HI, 3'h0, {6'h00, a[9:8]});
      acc(OP_ST, DS_CTRL, 3'h0, 8'h09);
   endtask
endmodule // ebac_core_model
`default_nettype wire

/* test/ebac_props.sv */
// Port checker for the nonvolatile byte access controller
`timescale 1ns/1ns
`default_nettype none
module ebac_props #(
   parameter logic [15:0] PROG_ATOMIC_CYC = 16'(ebac_pkg::ATOMIC_CYC),
   parameter logic [15:0] PROG_SPLIT_CYC  = 16'(ebac_pkg::SPLIT_CYC)
) (
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire ebac_pkg::ebac_req_s req_i,
   input wire logic [7:0]          rdata_o,
   input wire logic                bit_test_o,
   input wire logic                stall_o,
   input wire logic                ready_irq_o
);
   import ebac_pkg::*;
   // ************
   // Helpers
   // ************
   logic        ctl_w;
   logic        go_w;
   logic [2:0]  win_ff;
   logic [16:0] busy_ff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Launch needs an open window, a legal action and an idle device
   assign ctl_w = req_i.op == OP_ST && req_i.addr == DS_CTRL;
   assign go_w  = ctl_w && req_i.wdata[2:1] == 2'b11 && win_ff != 3'h0
                  && req_i.wdata[5:4] != 2'b11 && ready_irq_o && !stall_o;
   // Unlock window spans four request edges after the opening store
   always_ff @(posedge clk_i) begin
      if (rst_i) win_ff <= 3'h0;
      else if (ctl_w) win_ff <= (req_i.wdata[2] && !req_i.wdata[1]) ? 3'h4 : 3'h0;
      else if (win_ff != 3'h0) win_ff <= win_ff - 3'h1;
   end
   // Busy length; the first cycles are skipped since the ready level lags
   always_ff @(posedge clk_i) begin
      if (rst_i) busy_ff <= 17'h0;
      else if (go_w) busy_ff <= 17'h1;
      else if (busy_ff != 17'h0 && !(ready_irq_o && busy_ff > 17'h3)) busy_ff <= busy_ff + 17'h1;
      else busy_ff <= 17'h0;
   end
   sequence s_rd_go;
      ctl_w && req_i.wdata[0] && ready_irq_o && !stall_o;
   endsequence
   sequence s_scr_wr;
      req_i.op == OP_ST && req_i.addr == DS_SCR1;
   endsequence
   sequence s_scr_rd;
      req_i.op == OP_LD && req_i.addr == DS_SCR1;
   endsequence
   // ************
   // Assertions
   // ************
   a_read_stall_four: assert property (s_rd_go |=> stall_o [*4] ##1 !stall_o)
      else $error("read stall length wrong");
   a_write_stall_two: assert property (go_w |=> stall_o [*2] ##1 !stall_o)
      else $error("write stall length wrong");
   a_strobe_locked_out: assert property (ctl_w && req_i.wdata[1] && !req_i.wdata[0] && !stall_o
      && (win_ff == 3'h0 || req_i.wdata[5:4] == 2'b11) |=> !stall_o)
      else $error("locked strobe launched a write");
   a_irq_low_busy: assert property (go_w |-> ##2 (!ready_irq_o) [*4])
      else $error("ready level high while programming");
   a_write_self_timed: assert property (busy_ff <= {1'b0, PROG_ATOMIC_CYC} + 17'h4)
      else $error("write never completed");
   a_rdata_holds: assert property (!(req_i.op inside {OP_IN, OP_LD}) |=> $stable(rdata_o))
      else $error("read data changed without a read");
   a_reset_clears: assert property (disable iff (1'b0) rst_i |=>
      !stall_o && !bit_test_o && !ready_irq_o && rdata_o == 8'h00)
      else $error("outputs not cleared by reset");
   a_addr_high_zero: assert property (req_i.op == OP_LD && req_i.addr == DS_ADDR_HI
      |=> rdata_o[7:2] == 6'h00)
      else $error("upper address bits not zero");
   a_scratch_holds: assert property (s_scr_wr ##2 s_scr_rd |=> rdata_o == $past(req_i.wdata, 3))
      else $error("scratch value lost");
endmodule // ebac_props
`default_nettype wire

/* test/ebac_tb.sv */
// Self-checking bench for the nonvolatile byte access controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import ebac_pkg::*;
   localparam logic [7:0] RST_TAB [6] = '{DS_CTRL, DS_DATA, DS_SCR0, DS_SCR1, DS_SCR2, 8'h50};
   logic       clk_i;
   logic       rst_i;
   ebac_req_s  req;
   logic [7:0] rdata;
   logic       bit_tst;
   logic       stall;
   logic       rdy;
   logic       rd_seen;
   logic [8:0] exp_q [$];
   logic [8:0] ex;
   logic [9:0] a;
   logic [7:0] d;
   logic [7:0] d2;
   int         miscompares;
   int         checks;
   integer     seed;
   ebac_top #(.PROG_ATOMIC_CYC(16'h0014), .PROG_SPLIT_CYC(16'h000a)) dut (.clk_i(clk_i),
      .rst_i(rst_i), .req_i(req), .rdata_o(rdata), .bit_test_o(bit_tst), .stall_o(stall),
      .ready_irq_o(rdy));
   ebac_core_model core (.clk_i(clk_i), .stall_i(stall), .req_o(req));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // ************
   // Checking
   // ************
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rd(input ebac_op_e op, input logic [7:0] ad, input logic [2:0] bi,
                     input logic [7:0] e);
      exp_q.push_back({op == OP_TST, e});
      core.acc(op, ad, bi, 8'h00);
   endtask
   // A read result lands on its access edge and is checked at the next falling edge
   always @(posedge clk_i) rd_seen <= !rst_i && (req.op inside {OP_IN, OP_LD, OP_TST});
   always @(negedge clk_i) begin
      if (rd_seen === 1'b1) begin
         ex = exp_q.pop_front();
         cmp(ex[8] ? {7'h0, bit_tst} : rdata, ex[7:0]);
      end
   end
   // Ready level must drop while programming, then return within a bound
   task automatic finish_write;
      int n;
      n = 0;
      repeat (3) @(negedge clk_i);
      cmp({7'h0, rdy}, 8'h00);
      while (rdy !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      cmp({7'h0, rdy}, 8'h01);
   endtask
   task automatic print_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #(5000 * 100);
      miscompares++;
      print_verdict();
   end
   // ************
   // Scenarios
   // ************
   initial begin
      seed = 32'hecfe4430;
      miscompares = 0;
      checks = 0;
      rst_i = 1'b1;
      repeat (16) @(posedge clk_i);
      @(negedge clk_i) rst_i = 1'b0;
      foreach (RST_TAB[i]) rd(OP_LD, RST_TAB[i], 3'h0, 8'h00);
      core.acc(OP_ST, DS_ADDR_HI, 3'h0, 8'hff);
      rd(OP_LD, DS_ADDR_HI, 3'h0, 8'h03);
      $display("test reset_values done");
      d = 8'($random(seed));
      d2 = 8'($random(seed));
      core.acc(OP_OUT, 8'h1e, 3'h0, d);
      core.acc(OP_SBI, 8'h1e, 3'h3, 8'h00);
      core.acc(OP_CBI, 8'h1e, 3'h6, 8'h00);
      rd(OP_LD, DS_SCR0, 3'h0, (d | 8'h08) & 8'hbf);
      rd(OP_TST, 8'h1e, 3'h3, 8'h01);
      rd(OP_TST, 8'h1e, 3'h6, 8'h00);
      core.acc(OP_ST, DS_SCR1, 3'h0, d2);
      rd(OP_LD, DS_SCR1, 3'h0, d2);
      core.acc(OP_OUT, 8'h2b, 3'h0, ~d2);
      core.acc(d2[0] ? OP_SBI : OP_CBI, 8'h2b, 3'h0, 8'h00);
      core.acc(OP_OUT, 8'h4a, 3'h0, 8'h5a);
      rd(OP_IN, 8'h2b, 3'h0, ~d2);
      rd(OP_LD, DS_SCR1, 3'h0, d2);
      rd(OP_IN, 8'h4a, 3'h0, d2);
      core.acc(OP_ST, DS_CTRL, 3'h0, 8'h00);
      core.acc(OP_SBI, 8'h1f, 3'h3, 8'h00);
      rd(OP_LD, DS_CTRL, 3'h0, 8'h08);
      $display("test io_space done");
      a = 10'($random(seed));
      core.nv_write(a, d, 2'b00, 1'b1);
      finish_write();
      core.nv_read(a);
      rd(OP_LD, DS_DATA, 3'h0, d);
      core.nv_write(a, d2, 2'b01, 1'b1);
      finish_write();
      core.nv_read(a);
      rd(OP_LD, DS_DATA, 3'h0, 8'hff);
      core.nv_write(a, d2, 2'b10, 1'b1);
      finish_write();
      core.nv_write(a, d, 2'b10, 1'b1);
      finish_write();
      core.nv_read(a);
      rd(OP_LD, DS_DATA, 3'h0, d2 & d);
      core.nv_write(a, 8'h00, 2'b11, 1'b1);
      core.nv_write(a, 8'h00, 2'b00, 1'b0);
      core.acc(OP_ST, DS_CTRL, 3'h0, 8'h0c);
      repeat (3) @(negedge clk_i);
      core.acc(OP_ST, DS_CTRL, 3'h0, 8'h0e);
      repeat (30) @(negedge clk_i);
      core.nv_read(a);
      rd(OP_LD, DS_DATA, 3'h0, d2 & d);
      core.acc(OP_SBI, 8'h1f, 3'h2, 8'h00);
      core.acc(OP_SBI, 8'h1f, 3'h1, 8'h00);
      finish_write();
      $display("test write_modes done");
      core.nv_write(a, d2, 2'b00, 1'b1);
      core.acc(OP_ST, DS_ADDR_LO, 3'h0, ~a[7:0]);
      core.acc(OP_ST, DS_CTRL, 3'h0, 8'h29);
      rd(OP_LD, DS_CTRL, 3'h0, 8'h0a);
      @(negedge clk_i) rst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (30) @(negedge clk_i);
      rd(OP_LD, DS_ADDR_LO, 3'h0, a[7:0]);
      core.nv_read(a);
      rd(OP_LD, DS_DATA, 3'h0, d2);
      $display("test busy_and_reset done");
      print_verdict();
   end
endmodule // testbench
bind ebac_top ebac_props #(.PROG_ATOMIC_CYC(PROG_ATOMIC_CYC), .PROG_SPLIT_CYC(PROG_SPLIT_CYC))
   u_props (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
   .bit_test_o(bit_test_o), .stall_o(stall_o), .ready_irq_o(ready_irq_o));
`default_nettype wire

/* verilog/ebac_down_counter.sv */
// Loadable down-counter used for timeouts, stalls and the write timer
`timescale 1ns/1ns
`default_nettype none

module ebac_down_counter #(
   parameter int W           = 3,
   parameter bit KEEP_ON_RST = 1'b0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] load_val_i,
   output logic      [W-1:0] count_o,
   output logic              active_o,
   output logic              last_o
);

   logic [W-1:0] cnt_ff;

   // Reset clears it unless told to run through reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         if (KEEP_ON_RST && active_o) begin
            cnt_ff <= cnt_ff - W'(1);
         end else begin
            cnt_ff <= '0;
         end
      end else if (load_i) begin
         cnt_ff <= load_val_i;
      end else if (active_o) begin
         cnt_ff <= cnt_ff - W'(1);
      end
   end

   assign count_o  = cnt_ff;
   assign active_o = (cnt_ff != '0);
   assign last_o   = (cnt_ff == W'(1));

endmodule // ebac_down_counter

`default_nettype wire

/* verilog/ebac_nv_array.sv */
// Byte-wide nonvolatile storage array with erase and program commit
`timescale 1ns/1ns
`default_nettype none

module ebac_nv_array (
   input  wire logic                    clk_i,
   input  wire logic                    rd_en_i,
   input  wire logic [ebac_pkg::NV_AW-1:0] rd_addr_i,
   output logic      [7:0]              rdata_o,
   input  wire logic                    commit_i,
   input  wire logic [ebac_pkg::NV_AW-1:0] commit_addr_i,
   input  wire logic [7:0]              commit_data_i,
   input  wire ebac_pkg::ebac_pm_e      commit_mode_i
);
   import ebac_pkg::*;

   logic [7:0] mem [0:NV_BYTES-1];
   logic [7:0] rdata_ff;

   // Cells change only at the end of the timed write
   always_ff @(posedge clk_i) begin
      if (commit_i) begin
         unique case (commit_mode_i)
            PM_ATOMIC: mem[commit_addr_i] <= commit_data_i;
            PM_ERASE:  mem[commit_addr_i] <= 8'hff;
            PM_WRITE:  mem[commit_addr_i] <= mem[commit_addr_i] & commit_data_i;
            PM_RSVD:   ;                       // Reached when the launching store itself sets this code; cell kept
         endcase
      end
   end

   // Registered read port
   always_ff @(posedge clk_i) begin
      if (rd_en_i) begin
         rdata_ff <= mem[rd_addr_i];
      end
   end

   assign rdata_o = rdata_ff;

endmodule // ebac_nv_array

`default_nettype wire

/* verilog/ebac_top.sv */
// Nonvolatile byte access controller as seen from the core's I/O space
`timescale 1ns/1ns
`default_nettype none

module ebac_top #(
   parameter logic [15:0] PROG_ATOMIC_CYC = 16'(ebac_pkg::ATOMIC_CYC),
   parameter logic [15:0] PROG_SPLIT_CYC  = 16'(ebac_pkg::SPLIT_CYC)
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire ebac_pkg::ebac_req_s req_i,
   output logic      [7:0]          rdata_o,
   output logic                     bit_test_o,
   output logic                     stall_o,
   output logic                     ready_irq_o
);
   import ebac_pkg::*;

   // ******************************************
   // Declarations
   // ******************************************
   logic [7:0]          dsa;
   logic                acc_rd;
   logic                acc_wr;
   logic                acc_tst;
   logic [7:0]          wmask;
   logic [7:0]          wval;
   logic [7:0]          cur_val;
   logic                wr_ctrl;
   logic                wr_data;
   logic                wr_lo;
   logic                wr_hi;
   logic                wr_scr0;
   logic                wr_scr1;
   logic                wr_scr2;
   logic                launch_wr;
   logic                launch_rd;
   logic [7:0]          addr_lo_ff;
   logic [ADDR_HI_W-1:0] addr_hi_ff;
   logic [NV_AW-1:0]    nv_byte_address;
   logic [7:0]          data_ff;
   logic [7:0]          wr_data_ff;
   logic [7:0]          scr0_ff;
   logic [7:0]          scr1_ff;
   logic [7:0]          scr2_ff;
   ebac_pm_e            mode_ff;
   logic                irq_en_ff;
   logic                rd_pend_ff;
   logic [7:0]          rdata_ff;
   logic                bit_ff;
   logic                stall_ff;
   logic                ready_irq_ff;
   logic                unlock_load;
   logic [UNLOCK_W-1:0] unlock_val;
   logic                unlock_active;
   logic [PROG_W-1:0]   prog_val;
   logic                busy;
   logic                prog_last;
   logic                stall_load;
   logic [STALL_W-1:0]  stall_val;
   logic [STALL_W-1:0]  stall_cnt;
   logic [7:0]          nv_rdata;
   logic                nxt_stall;
   logic [1:0]          nxt_mode;

   // ******************************************
   // Register view
   // ******************************************
   // Unmapped and reserved locations read as zero
   function automatic logic [7:0] reg_view(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         DS_CTRL: begin
            v[CTRL_MODE_MSB:CTRL_MODE_LSB] = mode_ff;
            v[CTRL_IRQEN_BIT]  = irq_en_ff;
            v[CTRL_UNLOCK_BIT] = unlock_active;
            v[CTRL_STROBE_BIT] = busy;
         end
         DS_DATA:    v = data_ff;
         DS_ADDR_LO: v = addr_lo_ff;
         DS_ADDR_HI: v = {6'h00, addr_hi_ff};
         DS_SCR0:    v = scr0_ff;
         DS_SCR1:    v = scr1_ff;
         DS_SCR2:    v = scr2_ff;
         default:    v = 8'h00;
      endcase
      return v;
   endfunction

   // ******************************************
   // Access decode
   // ******************************************
   // Port-style accesses are rebased into data space; bit operations
   // are turned into a masked write so untouched bits keep their value
   always_comb begin
      dsa     = req_i.addr;
      acc_rd  = 1'b0;
      acc_wr  = 1'b0;
      acc_tst = 1'b0;
      wmask   = 8'hff;
      unique case (req_i.op)
         OP_NONE: ;
         OP_LD: acc_rd = 1'b1;
         OP_ST: acc_wr = 1'b1;
         OP_IN: begin
            dsa    = req_i.addr + IO_TO_DS;
            acc_rd = (req_i.addr < IO_LIMIT);
         end
         OP_OUT: begin
            dsa    = req_i.addr + IO_TO_DS;
            acc_wr = (req_i.addr < IO_LIMIT);
         end
         OP_SBI, OP_CBI: begin
            dsa    = req_i.addr + IO_TO_DS;
            acc_wr = (req_i.addr < BIT_LIMIT);
            wmask  = 8'h01 << req_i.bit_idx;
         end
         OP_TST: begin
            dsa     = req_i.addr + IO_TO_DS;
            acc_tst = (req_i.addr < BIT_LIMIT);
         end
      endcase
   end

   assign cur_val = reg_view(dsa);

   // Value to store: full byte, or one bit forced on or off
   always_comb begin
      wval = req_i.wdata;
      if (req_i.op == OP_SBI) begin
         wval = cur_val | wmask;
      end else if (req_i.op == OP_CBI) begin
         wval = cur_val & ~wmask;
      end
   end

   // Write selects per register
   assign wr_ctrl = acc_wr && (dsa == DS_CTRL);
   assign wr_data = acc_wr && (dsa == DS_DATA);
   assign wr_lo   = acc_wr && (dsa == DS_ADDR_LO);
   assign wr_hi   = acc_wr && (dsa == DS_ADDR_HI);
   assign wr_scr0 = acc_wr && (dsa == DS_SCR0);
   assign wr_scr1 = acc_wr && (dsa == DS_SCR1);
   assign wr_scr2 = acc_wr && (dsa == DS_SCR2);

   // ******************************************
   // Launch conditions
   // ******************************************
   // A strobe without a live unlock window does nothing; the reserved
   // action code is refused when already held, not when the strobe store itself sets it
   assign launch_wr = wr_ctrl && wmask[CTRL_STROBE_BIT] && wval[CTRL_STROBE_BIT]
                      && unlock_active && !busy && (mode_ff != PM_RSVD);

   // Reads are dropped while the array is busy programming
   assign launch_rd = wr_ctrl && wmask[CTRL_READ_BIT] && wval[CTRL_READ_BIT]
                      && !busy;

   // ******************************************
   // Unlock window
   // ******************************************
   // Writing one opens a four-cycle window, writing zero shuts it
   assign unlock_load = wr_ctrl && wmask[CTRL_UNLOCK_BIT];
   assign unlock_val  = wval[CTRL_UNLOCK_BIT] ? UNLOCK_W'(UNLOCK_CYC)
                                              : UNLOCK_W'(0);

   ebac_down_counter #(
      .W           (UNLOCK_W),
      .KEEP_ON_RST (1'b0)
   ) u_unlock (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .load_i     (unlock_load),
      .load_val_i (unlock_val),
      .count_o    (),
      .active_o   (unlock_active),
      .last_o     ()
   );

   // ******************************************
   // Self-timed program timer
   // ******************************************
   // Duration depends on the selected action
   assign prog_val = (mode_ff == PM_ATOMIC) ? PROG_ATOMIC_CYC : PROG_SPLIT_CYC;

   // Keeps running through reset so a started write is never cut short
   ebac_down_counter #(
      .W           (PROG_W),
      .KEEP_ON_RST (1'b1)
   ) u_prog (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .load_i     (launch_wr),
      .load_val_i (prog_val),
      .count_o    (),
      .active_o   (busy),
      .last_o     (prog_last)
   );

   // ******************************************
   // Core stall
   // ******************************************
   assign stall_load = launch_rd || launch_wr;
   assign stall_val  = launch_rd ? STALL_W'(RD_STALL_CYC)
                                 : STALL_W'(WR_STALL_CYC);

   ebac_down_counter #(
      .W           (STALL_W),
      .KEEP_ON_RST (1'b0)
   ) u_stall (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .load_i     (stall_load),
      .load_val_i (stall_val),
      .count_o    (stall_cnt),
      .active_o   (),
      .last_o     ()
   );

   // Held from the cycle after the launch for exactly the stall count
   assign nxt_stall = stall_load || (stall_cnt > STALL_W'(1));

   always_ff @(posedge clk_i) begin
      stall_ff <= !rst_i && nxt_stall;
   end

   // ******************************************
   // Storage array
   // ******************************************
   assign nv_byte_address = {addr_hi_ff, addr_lo_ff};

   // Address is frozen while busy, so it is safe to use at commit
   ebac_nv_array u_array (
      .clk_i         (clk_i),
      .rd_en_i       (launch_rd),
      .rd_addr_i     (nv_byte_address),
      .rdata_o       (nv_rdata),
      .commit_i      (prog_last),
      .commit_addr_i (nv_byte_address),
      .commit_data_i (wr_data_ff),
      .commit_mode_i (mode_ff)
   );

   // ******************************************
   // Address registers
   // ******************************************
   // No reset: software must load an address before any access
   always_ff @(posedge clk_i) begin
      if (wr_lo && !busy) begin
         addr_lo_ff <= wval;
      end
      if (wr_hi && !busy) begin
         addr_hi_ff <= wval[ADDR_HI_W-1:0];
      end
   end

   // ******************************************
   // Data register and write latch
   // ******************************************
   // A completing read overrides a software write in the same cycle;
   // the core is stalled then, so the collision cannot come from it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_ff <= DATA_RST;
      end else if (rd_pend_ff) begin
         data_ff <= nv_rdata;
      end else if (wr_data) begin
         data_ff <= wval;
      end
   end

   // Data is captured at launch since the data register stays writable
   always_ff @(posedge clk_i) begin
      if (launch_wr) begin
         wr_data_ff <= data_ff;
      end
   end

   // The array answers one cycle after the strobe edge
   always_ff @(posedge clk_i) begin
      rd_pend_ff <= !rst_i && launch_rd;
   end

   // ******************************************
   // Control fields
   // ******************************************
   // Only the mode bits that the access addresses take the new value
   assign nxt_mode = (wval[CTRL_MODE_MSB:CTRL_MODE_LSB] & wmask[CTRL_MODE_MSB:CTRL_MODE_LSB])
                   | (mode_ff & ~wmask[CTRL_MODE_MSB:CTRL_MODE_LSB]);

   // Action select survives reset while a write is still running
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_ff <= busy ? mode_ff : MODE_RST;
      end else if (wr_ctrl && !busy) begin
         mode_ff <= ebac_pm_e'(nxt_mode);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_ff <= 1'b0;
      end else if (wr_ctrl && wmask[CTRL_IRQEN_BIT]) begin
         irq_en_ff <= wval[CTRL_IRQEN_BIT];
      end
   end

   // Level request: stands as long as the array is idle and enabled
   always_ff @(posedge clk_i) begin
      ready_irq_ff <= !rst_i && irq_en_ff && !busy;
   end

   // ******************************************
   // Scratch registers
   // ******************************************
   // Plain storage; the first sits in the bit-accessible range
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scr0_ff <= SCR_RST;
         scr1_ff <= SCR_RST;
         scr2_ff <= SCR_RST;
      end else begin
         if (wr_scr0) begin
            scr0_ff <= wval;
         end
         if (wr_scr1) begin
            scr1_ff <= wval;
         end
         if (wr_scr2) begin
            scr2_ff <= wval;
         end
      end
   end

   // ******************************************
   // Read answers
   // ******************************************
   // Read data and bit-test result appear the cycle after the access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= 8'h00;
      end else if (acc_rd) begin
         rdata_ff <= cur_val;
      end
   end

   // The core decides the skip from this bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_ff <= 1'b0;
      end else if (acc_tst) begin
         bit_ff <= cur_val[req_i.bit_idx];
      end
   end

   // ******************************************
   // Outputs
   // ******************************************
   assign rdata_o     = rdata_ff;
   assign bit_test_o  = bit_ff;
   assign stall_o     = stall_ff;
   assign ready_irq_o = ready_irq_ff;

endmodule // ebac_top

`default_nettype wire
